// [flag_latch.v]
// One status flag that latches high on an event or latches low on a dropped condition.
`timescale 1ns/1ps

module flag_latch
#(
  parameter LATCH_LOW = 0
)
(
  clk_sys,
  srst,
  ce,
  live,
  clr,
  flag
);
  input  wire clk_sys;
  input  wire srst;
  input  wire ce;
  input  wire live;
  input  wire clr;
  output wire flag;

  reg flag_r;
  reg flag_nxt;

  // A latched-high flag lets the event win over a clearing read in the same cycle, so none is lost.
  // A latched-low flag keeps its zero until read, then follows the live condition again.
  always @*
  begin
    if (LATCH_LOW != 0)
      flag_nxt = clr ? live : (flag_r & live);
    else
      flag_nxt = live | (flag_r & ~clr);
  end

  // Flag storage, frozen while the clock enable is low.
  always @(posedge clk_sys)
  begin
    if (srst)
      flag_r <= 1'b0;
    else if (ce)
      flag_r <= flag_nxt;
  end

  assign flag = flag_r;
endmodule

// [phy_status_defs.vh]
// Register indices, field positions, reset values and widths of the status summary block.
`ifndef PHY_STATUS_DEFS_VH
`define PHY_STATUS_DEFS_VH

// Register indices; the byte address on the bus is four times the index.
`define IDX_BASIC_CONTROL     8'h00
`define IDX_BASIC_STATUS      8'h01
`define IDX_AUTONEG_EXPANSION 8'h06
`define IDX_SUMMARY           8'h10
`define IDX_INT_STATUS_EVENT  8'h12
`define IDX_FALSE_CARRIER_CNT 8'h14
`define IDX_RX_ERROR_CNT      8'h15
`define IDX_PCS_CONFIG        8'h16
`define IDX_TEN_MBIT_STATUS   8'h1A
`define IDX_INT_MASK          8'h1C

// Summary register bit positions.
`define SUM_RX_ERR_LATCH      13
`define SUM_POLARITY          12
`define SUM_FALSE_CARRIER     11
`define SUM_SIGNAL_DETECT     10
`define SUM_DESCR_LOCK        9
`define SUM_PAGE_RECEIVED     8
`define SUM_INT_PENDING       7
`define SUM_REMOTE_FAULT      6
`define SUM_JABBER            5
`define SUM_AUTONEG_DONE      4
`define SUM_LOOPBACK          3

// Bits in the other registers that feed or clear the summary.
`define CTL_LOOPBACK_BIT      14
`define STS_AUTONEG_DONE_BIT  5
`define STS_REMOTE_FAULT_BIT  4
`define STS_JABBER_BIT        1
`define EXP_PAGE_RX_BIT       1
`define CFG_SD_QUAL_BIT       8
`define TEN_POLARITY_BIT      4

// Widths and reset values.
`define REG_W                 16
`define CNT_W                 8
`define CNT_MAX               8'hFF
`define EVT_W                 8
`define NUM_PINS              9
`define NUM_LATCH             8
`define REG_RESET             16'h0000
`define EVT_RESET             8'h00

`endif

// [phy_status_summary.v]
// Status summary register bank with its feeding flags, counters and Avalon-MM slave.
//
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/1ps
`include "phy_status_defs.vh"

// Notes on behaviour
// - Bit 13 latches any receive error until the receive error counter is read.
// - Bit 12 mirrors polarity flag, cleared only by reading the 10 Mb/s status.
// - Bit 11 latches false carrier until the false carrier counter is read.
// - Bit 10 is signal detect, optionally ANDed with descrambler lock by config bit 8.
// - Bit 9 is descrambler lock, latched low, reset value zero.
// - Bit 8 mirrors page received, cleared only by reading the expansion register.
// - Bit 7 shows a pending interrupt; reading the interrupt status clears it.
// - Bit 6 latches remote fault until basic status is read or reset.
// - Bit 5 mirrors jabber from basic status; summary reads leave it alone.
// - Bit 4 shows autonegotiation complete, bit 3 shows loopback enabled.
module phy_status_summary
(
  clk_sys,
  srst,
  ce,
  avs_address,
  avs_read,
  avs_write,
  avs_writedata,
  avs_byteenable,
  avs_readdata,
  avs_waitrequest,
  rx_error_evt,
  false_carrier_evt,
  polarity_inverted,
  page_received_evt,
  remote_fault_evt,
  jabber_detect,
  raw_signal_detect,
  descrambler_lock,
  autoneg_done,
  loopback_en,
  irq
);
  input  wire        clk_sys;
  input  wire        srst;
  input  wire        ce;
  input  wire [9:0]  avs_address;
  input  wire        avs_read;
  input  wire        avs_write;
  input  wire [31:0] avs_writedata;
  input  wire [3:0]  avs_byteenable;
  output wire [31:0] avs_readdata;
  output wire        avs_waitrequest;
  input  wire        rx_error_evt;
  input  wire        false_carrier_evt;
  input  wire        polarity_inverted;
  input  wire        page_received_evt;
  input  wire        remote_fault_evt;
  input  wire        jabber_detect;
  input  wire        raw_signal_detect;
  input  wire        descrambler_lock;
  input  wire        autoneg_done;
  output wire        loopback_en;
  output wire        irq;

  // Latch slots in the generate loop below.
  localparam L_RX_ERR = 0;
  localparam L_FC     = 1;
  localparam L_POL    = 2;
  localparam L_PAGE   = 3;
  localparam L_RF     = 4;
  localparam L_JAB    = 5;
  localparam L_SIGDET = 6;
  localparam L_LOCK   = 7;

  wire [`NUM_PINS-1:0]  pins_in;
  reg  [`NUM_PINS-1:0]  sync1_r;
  reg  [`NUM_PINS-1:0]  sync2_r;
  reg  [`NUM_PINS-1:0]  prev_r;
  wire [`NUM_PINS-1:0]  rise;
  reg                   ack_r;
  reg  [31:0]           rdata_r;
  reg  [31:0]           rdata_nxt;
  reg  [`REG_W-1:0]     ctrl_r;
  reg  [`REG_W-1:0]     cfg_r;
  reg  [`CNT_W-1:0]     rx_cnt_r;
  reg  [`CNT_W-1:0]     fc_cnt_r;
  reg  [`EVT_W-1:0]     evt_r;
  reg  [`EVT_W-1:0]     mask_r;
  reg                   pend_r;
  wire                  req;
  wire                  done;
  wire                  rd_done;
  wire                  wr_done;
  wire [7:0]            idx;
  wire [15:0]           lane;
  wire [15:0]           wdata;
  wire [`NUM_LATCH-1:0] lat_in;
  wire [`NUM_LATCH-1:0] lat_clr;
  wire [`NUM_LATCH-1:0] lat_q;
  wire [`EVT_W-1:0]     evt_in;
  wire [`EVT_W-1:0]     evt_w1c;
  wire                  sd_qual;
  wire                  an_done_s;
  wire [`REG_W-1:0]     summary;
  wire [`REG_W-1:0]     basic_status;

  // All status inputs come from the line-side logic outside this clock domain.
  assign pins_in = {autoneg_done, descrambler_lock, raw_signal_detect, jabber_detect,
                    remote_fault_evt, page_received_evt, polarity_inverted,
                    false_carrier_evt, rx_error_evt};

  // Two-flop synchroniser; edges are taken from the second stage only.
  always @(posedge clk_sys)
  begin
    if (srst)
    begin
      sync1_r <= 9'h000;
      sync2_r <= 9'h000;
      prev_r  <= 9'h000;
    end
    else if (ce)
    begin
      sync1_r <= pins_in;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  assign rise      = sync2_r & ~prev_r;
  assign an_done_s = sync2_r[8];

  // Bus handshake: every access made while ce is high sees exactly one wait state, so read data are ready in time.
  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_r;
  assign done            = req & ack_r & ce;
  assign rd_done         = done & avs_read;
  assign wr_done         = done & avs_write;
  assign idx             = avs_address[9:2];
  assign lane            = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wdata           = avs_writedata[15:0];
  assign avs_readdata    = rdata_r;

  always @(posedge clk_sys)
  begin
    if (srst)
      ack_r <= 1'b0;
    else if (ce)
      ack_r <= req & ~ack_r;
  end

  // Qualified signal detect: descrambler lock is folded in only when the config bit asks for it.
  assign sd_qual = sync2_r[6] & (cfg_r[`CFG_SD_QUAL_BIT] ? sync2_r[7] : 1'b1);

  // Inputs to the flag latches; counted events use edges, conditions use levels.
  assign lat_in[L_RX_ERR] = rise[0];
  assign lat_in[L_FC]     = rise[1];
  assign lat_in[L_POL]    = sync2_r[2];
  assign lat_in[L_PAGE]   = rise[3];
  assign lat_in[L_RF]     = rise[4];
  assign lat_in[L_JAB]    = sync2_r[5];
  assign lat_in[L_SIGDET] = sd_qual;
  assign lat_in[L_LOCK]   = sync2_r[7];

  // Each flag clears only on a read of its home register, never on a summary read for mirrors.
  assign lat_clr[L_RX_ERR] = rd_done & (idx == `IDX_RX_ERROR_CNT);
  assign lat_clr[L_FC]     = rd_done & (idx == `IDX_FALSE_CARRIER_CNT);
  assign lat_clr[L_POL]    = rd_done & (idx == `IDX_TEN_MBIT_STATUS);
  assign lat_clr[L_PAGE]   = rd_done & (idx == `IDX_AUTONEG_EXPANSION);
  assign lat_clr[L_RF]     = rd_done & (idx == `IDX_BASIC_STATUS);
  assign lat_clr[L_JAB]    = rd_done & (idx == `IDX_BASIC_STATUS);
  assign lat_clr[L_SIGDET] = rd_done & (idx == `IDX_SUMMARY);
  assign lat_clr[L_LOCK]   = rd_done & (idx == `IDX_SUMMARY);

  // One latch per flag; the two line-quality flags latch low, the rest latch high.
  genvar gi;
  generate
    for (gi = 0; gi < `NUM_LATCH; gi = gi + 1)
    begin : g_latch
      flag_latch
      #(
        .LATCH_LOW ((gi >= L_SIGDET) ? 1 : 0)
      )
      u_latch
      (
        .clk_sys (clk_sys),
        .srst    (srst),
        .ce      (ce),
        .live    (lat_in[gi]),
        .clr     (lat_clr[gi]),
        .flag    (lat_q[gi])
      );
    end
  endgenerate

  // Event counters saturate rather than wrap, so a burst never reads back as a small number.
  // A count in the same cycle as the clearing read starts the new count at one.
  always @(posedge clk_sys)
  begin
    if (srst)
    begin
      rx_cnt_r <= 8'h00;
      fc_cnt_r <= 8'h00;
    end
    else if (ce)
    begin
      if (lat_clr[L_RX_ERR])
        rx_cnt_r <= {7'h00, rise[0]};
      else if (rise[0] && rx_cnt_r != `CNT_MAX)
        rx_cnt_r <= rx_cnt_r + 8'h01;
      if (lat_clr[L_FC])
        fc_cnt_r <= {7'h00, rise[1]};
      else if (rise[1] && fc_cnt_r != `CNT_MAX)
        fc_cnt_r <= fc_cnt_r + 8'h01;
    end
  end

  // Interrupt events: bits 5..0 in flag order, bit 6 autonegotiation done rising, bit 7 raw signal detect falling.
  assign evt_in = {prev_r[6] & ~sync2_r[6],
                   rise[8], rise[5], rise[4], rise[3], rise[2], rise[1], rise[0]};
  assign evt_w1c = (wr_done && idx == `IDX_INT_STATUS_EVENT) ?
                   (wdata[`EVT_W-1:0] & lane[`EVT_W-1:0]) : `EVT_RESET;

  // Sticky event bits: a new event wins over a write-one clear in the same cycle.
  // The pending flag is set by any unmasked event and cleared by reading the event register.
  always @(posedge clk_sys)
  begin
    if (srst)
    begin
      evt_r  <= `EVT_RESET;
      pend_r <= 1'b0;
    end
    else if (ce)
    begin
      evt_r <= evt_in | (evt_r & ~evt_w1c);
      if (|(evt_in & mask_r))
        pend_r <= 1'b1;
      else if (rd_done && idx == `IDX_INT_STATUS_EVENT)
        pend_r <= 1'b0;
    end
  end

  assign irq = |(evt_r & mask_r);

  // Writable registers: loopback control, signal detect qualification and interrupt mask.
  always @(posedge clk_sys)
  begin
    if (srst)
    begin
      ctrl_r <= `REG_RESET;
      cfg_r  <= `REG_RESET;
      mask_r <= `EVT_RESET;
    end
    else if (wr_done)
    begin
      case (idx)
        `IDX_BASIC_CONTROL:
          ctrl_r <= (ctrl_r & ~lane) | (wdata & lane);
        `IDX_PCS_CONFIG:
          cfg_r <= (cfg_r & ~lane) | (wdata & lane);
        `IDX_INT_MASK:
          mask_r <= (mask_r & ~lane[7:0]) | (wdata[7:0] & lane[7:0]);
        default:
          ctrl_r <= ctrl_r;
      endcase
    end
  end

  assign loopback_en = ctrl_r[`CTL_LOOPBACK_BIT];

  // Basic status view; reading it clears remote fault and jabber.
  assign basic_status = {10'h000, an_done_s, lat_q[L_RF], 2'b00, lat_q[L_JAB], 1'b0};

  // Summary word; bits outside 13..3 are not held in this bank and read as zero.
  assign summary = {2'b00,
                    lat_q[L_RX_ERR],
                    lat_q[L_POL],
                    lat_q[L_FC],
                    lat_q[L_SIGDET],
                    lat_q[L_LOCK],
                    lat_q[L_PAGE],
                    pend_r,
                    lat_q[L_RF],
                    lat_q[L_JAB],
                    an_done_s,
                    ctrl_r[`CTL_LOOPBACK_BIT],
                    3'b000};

  // Read multiplexer; unmapped indices read as zero.
  always @*
  begin
    rdata_nxt = 32'h0000_0000;
    case (idx)
      `IDX_BASIC_CONTROL:     rdata_nxt[15:0] = ctrl_r;
      `IDX_BASIC_STATUS:      rdata_nxt[15:0] = basic_status;
      `IDX_AUTONEG_EXPANSION: rdata_nxt[`EXP_PAGE_RX_BIT] = lat_q[L_PAGE];
      `IDX_SUMMARY:           rdata_nxt[15:0] = summary;
      `IDX_INT_STATUS_EVENT:  rdata_nxt[7:0] = evt_r;
      `IDX_FALSE_CARRIER_CNT: rdata_nxt[7:0] = fc_cnt_r;
      `IDX_RX_ERROR_CNT:      rdata_nxt[7:0] = rx_cnt_r;
      `IDX_PCS_CONFIG:        rdata_nxt[15:0] = cfg_r;
      `IDX_TEN_MBIT_STATUS:   rdata_nxt[`TEN_POLARITY_BIT] = lat_q[L_POL];
      `IDX_INT_MASK:          rdata_nxt[7:0] = mask_r;
      default:                rdata_nxt = 32'h0000_0000;
    endcase
  end

  // Read data are captured in the wait cycle and stand through the completing edge.
  always @(posedge clk_sys)
  begin
    if (srst)
      rdata_r <= 32'h0000_0000;
    else if (ce && avs_read && !ack_r)
      rdata_r <= rdata_nxt;
  end
endmodule

// [summary_checker.sv]
// Port assertions for the status summary register bank.
`timescale 1ns/1ps
module summary_checker
(
  input wire        clk_sys,
  input wire        srst,
  input wire [9:0]  avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  input wire        rx_error_evt,
  input wire        false_carrier_evt,
  input wire        polarity_inverted,
  input wire        page_received_evt,
  input wire        remote_fault_evt,
  input wire        jabber_detect,
  input wire        raw_signal_detect,
  input wire        descrambler_lock,
  input wire        loopback_en,
  input wire        irq
);
  // A summary read completes; its data were captured one edge earlier.
  wire sum_done;
  assign sum_done = avs_read & ~avs_waitrequest & (avs_address[9:2] == 8'h10);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  // Every fresh request gets exactly one wait state.
  sequence s_new; $rose(avs_read) || $rose(avs_write); endsequence
  sequence s_ack; avs_waitrequest ##1 !avs_waitrequest; endsequence
  property p_one_wait; s_new |-> s_ack; endproperty
  a_one_wait: assert property (p_one_wait) else $error("wait state count");
  // An event pin high five cycles back must already show as a latched flag.
  property p_rx; sum_done && $past(rx_error_evt, 5) |-> avs_readdata[13]; endproperty
  a_rx: assert property (p_rx) else $error("rx error flag");
  property p_fc; sum_done && $past(false_carrier_evt, 5) |-> avs_readdata[11]; endproperty
  a_fc: assert property (p_fc) else $error("false carrier flag");
  property p_pg; sum_done && $past(page_received_evt, 5) |-> avs_readdata[8]; endproperty
  a_pg: assert property (p_pg) else $error("page flag");
  property p_rf; sum_done && $past(remote_fault_evt, 5) |-> avs_readdata[6]; endproperty
  a_rf: assert property (p_rf) else $error("remote fault flag");
  // Levels held for six cycles have passed the synchroniser by capture time.
  property p_pol; polarity_inverted [*6] ##0 sum_done |-> avs_readdata[12]; endproperty
  a_pol: assert property (p_pol) else $error("polarity flag");
  property p_jab; jabber_detect [*6] ##0 sum_done |-> avs_readdata[5]; endproperty
  a_jab: assert property (p_jab) else $error("jabber flag");
  property p_lock; !descrambler_lock [*6] ##0 sum_done |-> !avs_readdata[9]; endproperty
  a_lock: assert property (p_lock) else $error("lock flag");
  property p_sd; !raw_signal_detect [*6] ##0 sum_done |-> !avs_readdata[10]; endproperty
  a_sd: assert property (p_sd) else $error("signal detect flag");
  property p_loop; sum_done |-> avs_readdata[3] == loopback_en; endproperty
  a_loop: assert property (p_loop) else $error("loopback flag");
  // Reset must leave outputs quiet; this one is not disabled by reset.
  property p_rst; disable iff (1'b0) srst |=> !irq && !loopback_en; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
endmodule

bind phy_status_summary summary_checker chk_u (.*);

// [tb.sv]
// Self-checking bench for the status summary register bank.
`timescale 1ns/1ps
module tb;
  logic        clk_sys;
  logic        srst;
  logic [9:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  wire  [31:0] avs_readdata;
  wire         avs_waitrequest;
  wire         loopback_en;
  wire         irq;
  logic [5:0]  stim;
  logic        sd;
  logic        lock;
  logic        an;
  logic [15:0] rd;
  integer      fail_count;
  integer      n_compared;
  integer      cyc = 0;
  integer      i;
  // Per event pin: summary bit, clearing register, its mask and reading.
  logic [15:0] sbit [0:5] = '{16'h2000, 16'h0800, 16'h0100, 16'h0040, 16'h1000, 16'h0020};
  logic [7:0]  cidx [0:5] = '{8'h15, 8'h14, 8'h06, 8'h01, 8'h1A, 8'h01};
  logic [15:0] cmsk [0:5] = '{16'h00FF, 16'h00FF, 16'h0002, 16'h0010, 16'h0010, 16'h0002};
  logic [15:0] cexp [0:5] = '{16'h0001, 16'h0001, 16'h0002, 16'h0010, 16'h0010, 16'h0002};

  phy_status_summary dut_u
  (
    .ce(1'b1),
    .avs_byteenable(4'h3),
    .rx_error_evt(stim[0]),
    .false_carrier_evt(stim[1]),
    .page_received_evt(stim[2]),
    .remote_fault_evt(stim[3]),
    .polarity_inverted(stim[4]),
    .jabber_detect(stim[5]),
    .raw_signal_detect(sd),
    .descrambler_lock(lock),
    .autoneg_done(an),
    .*
  );

  // Clock at 40 MHz.
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // Cycle ceiling, so a stuck handshake still ends the run.
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      fail_count = fail_count + 1;
      wrap_up;
    end
  end

  task wrap_up;
    begin
      $display("compared %0d, wrong %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask

  task chk(input logic [15:0] got, input logic [15:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp)
      begin
        fail_count = fail_count + 1;
        $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
    end
  endtask

  // One Avalon transfer; the request holds until waitrequest is seen low.
  task bus(input logic wr, input logic [7:0] idx, input logic [15:0] wd);
    begin
      @(posedge clk_sys);
      avs_address <= {idx, 2'b00};
      avs_writedata <= {16'h0000, wd};
      avs_read <= ~wr;
      avs_write <= wr;
      // Waitrequest is read before this edge's updates land, so it is the value the slave shows.
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0)
        @(posedge clk_sys);
      rd = avs_readdata[15:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
    end
  endtask

  task rdc(input logic [7:0] idx, input logic [15:0] msk, input logic [15:0] exp);
    begin
      bus(1'b0, idx, 16'h0000);
      chk(rd & msk, exp);
    end
  endtask

  // Main sequence; waits of eight cycles let pins cross the synchroniser.
  initial
  begin
    srst = 1'b1;
    avs_address = 10'h000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    stim = 6'h00;
    sd = 1'b0;
    lock = 1'b0;
    an = 1'b0;
    fail_count = 0;
    n_compared = 0;
    repeat (10) @(posedge clk_sys);
    srst <= 1'b0;
    rdc(8'h10, 16'h3FF8, 16'h0000);
    chk({14'h0000, irq, loopback_en}, 16'h0000);
    for (i = 0; i < 6; i = i + 1)
    begin
      stim[i] <= 1'b1;
      repeat (8) @(posedge clk_sys);
      rdc(8'h10, sbit[i] | 16'h0080, sbit[i]);
      stim[i] <= 1'b0;
      rdc(8'h10, sbit[i], sbit[i]);
      rdc(cidx[i], cmsk[i], cexp[i]);
      rdc(8'h10, sbit[i], 16'h0000);
    end
    // Unmasked receive error raises the pending bit and the interrupt.
    bus(1'b1, 8'h12, 16'h00FF);
    bus(1'b1, 8'h1C, 16'h0001);
    stim[0] <= 1'b1;
    repeat (2) @(posedge clk_sys);
    stim[0] <= 1'b0;
    repeat (8) @(negedge clk_sys);
    chk({15'h0000, irq}, 16'h0001);
    rdc(8'h10, 16'h0080, 16'h0080);
    rdc(8'h12, 16'h00FF, 16'h0001);
    rdc(8'h10, 16'h0080, 16'h0000);
    bus(1'b1, 8'h12, 16'h0001);
    @(negedge clk_sys);
    chk({15'h0000, irq}, 16'h0000);
    // Latched-low lock and the optional qualification of signal detect.
    @(posedge clk_sys);
    sd <= 1'b1;
    lock <= 1'b1;
    repeat (8) @(posedge clk_sys);
    rdc(8'h10, 16'h0600, 16'h0000);
    rdc(8'h10, 16'h0600, 16'h0600);
    lock <= 1'b0;
    repeat (8) @(posedge clk_sys);
    lock <= 1'b1;
    repeat (8) @(posedge clk_sys);
    rdc(8'h10, 16'h0600, 16'h0400);
    rdc(8'h10, 16'h0600, 16'h0600);
    bus(1'b1, 8'h16, 16'h0100);
    lock <= 1'b0;
    repeat (8) @(posedge clk_sys);
    rdc(8'h10, 16'h0600, 16'h0000);
    // Autonegotiation done, loopback on, a write to the read-only summary.
    an <= 1'b1;
    bus(1'b1, 8'h00, 16'h4000);
    bus(1'b1, 8'h10, 16'h0000);
    @(negedge clk_sys);
    chk({15'h0000, loopback_en}, 16'h0001);
    rdc(8'h10, 16'h0018, 16'h0018);
    rdc(8'h3F, 16'hFFFF, 16'h0000);
    wrap_up;
  end
endmodule
